// File: poc_board.sv
// Board model: shared clock source and pin levels.
// Assumes the bench starts and stops the clock between frames.
`timescale 1ns/1ps
module poc_board (
  input wire logic i_ref_clk,
  input wire logic i_run,
  input wire logic [9:0] i_drive,
  input wire logic [9:0] i_o_pin,
  input wire logic [9:0] i_o_pin_oe,
  output logic o_ext_clk,
  output logic [9:0] o_pin
);
  logic [1:0] div;
  always_ff @(posedge i_ref_clk) begin
    div <= i_run ? div + 2'h1 : 2'h0;
  end
  assign o_ext_clk = div[1];
  // Board drives released pins
  assign o_pin = (i_o_pin_oe & i_o_pin) | (~i_o_pin_oe & i_drive);
endmodule // poc_board

// File: poc_cell.sv
// One output cell: register, clock select, load control, output enable.
// Assumes product-term inputs and configuration are synchronous and static.
`timescale 1ns/1ps
module poc_cell (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_ext_clk,
  input wire logic i_clk_sel,
  input wire logic i_reg_sel,
  input wire poc_pkg::poc_mode_e i_mode,
  input wire poc_pkg::poc_oe_e i_oe_sel,
  input wire logic i_polarity,
  input wire logic i_cell_term_clock,
  input wire logic i_load_control_term,
  input wire logic i_type_switch_term,
  input wire logic i_cell_reset_term,
  input wire logic i_d_term,
  input wire logic i_j_term,
  input wire logic i_k_term,
  input wire logic i_comb_term,
  input wire logic i_oe_term,
  input wire logic i_oe_n,
  input wire logic i_pin,
  output logic o_pin,
  output logic o_pin_oe,
  output logic o_reg_fb,
  output logic o_pin_fb
);
  logic q;
  logic next_q;
  logic clk_prev;
  logic sel_clk;
  logic clk_rise;
  logic jk_mode;
  logic oe;
  logic next_pin;
  always_comb begin
    sel_clk = (i_clk_sel == poc_pkg::CLKSEL_EXTERNAL) ? i_ext_clk : i_cell_term_clock; // [R1] [R2]
    clk_rise = sel_clk & ~clk_prev; // [R17]
    jk_mode = (i_reg_sel != poc_pkg::REGSEL_D) ^ i_type_switch_term; // [R11] [R18]
    if (i_load_control_term) begin
      next_q = i_pin; // [R7] [R9]
    end else if (jk_mode) begin
      next_q = (i_j_term & ~q) | (~i_k_term & q);
    end else begin
      next_q = i_d_term;
    end
    unique case (i_oe_sel)
      poc_pkg::POC_OE_PIN: oe = ~i_oe_n; // [R12]
      poc_pkg::POC_OE_TERM: oe = i_oe_term; // [R13]
      default: oe = 1'b1; // [R13]
    endcase
    if (i_mode == poc_pkg::POC_DED_IN || i_mode == poc_pkg::POC_REG_IN) begin
      oe = 1'b0; // [R6] [R9]
    end
    if (i_mode == poc_pkg::POC_COMB_IO || i_mode == poc_pkg::POC_DED_IO) begin
      next_pin = i_comb_term ^ i_polarity; // [R5] [R14]
    end else begin
      next_pin = ~q;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_prev <= 1'b0;
    end else if (i_ce) begin
      clk_prev <= sel_clk;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= poc_pkg::RST_Q;
    end else if (i_ce) begin
      if (i_cell_reset_term) begin
        q <= poc_pkg::RST_Q; // [R19]
      end else if (clk_rise) begin
        q <= next_q; // [R17] [R8]
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
      o_reg_fb <= 1'b0;
      o_pin_fb <= 1'b0;
    end else if (i_ce) begin
      o_pin <= next_pin; // [R8]
      o_pin_oe <= oe; // [R6]
      o_reg_fb <= q; // [R5]
      o_pin_fb <= oe ? next_pin : i_pin; // [R6]
    end
  end
endmodule // poc_cell

// File: poc_pkg.sv
// Package of constants and types for the programmable output cell array.
// Assumes a single 100 MHz reference clock and static configuration inputs.
package poc_pkg;
  localparam int CELL_COUNT = 10;
  localparam int TERM_INPUTS = 8;
  localparam logic RST_Q = 1'b0;
  localparam logic CLKSEL_EXTERNAL = 1'b0;
  localparam logic REGSEL_D = 1'b0;
  typedef enum logic [2:0] {
    POC_REG_OUT = 3'b000,
    POC_REG_IN = 3'b001,
    POC_COMB_IO = 3'b010,
    POC_DED_IN = 3'b011,
    POC_DED_IO = 3'b100
  } poc_mode_e;
  typedef enum logic [1:0] {
    POC_OE_PIN = 2'b00,
    POC_OE_TERM = 2'b01,
    POC_OE_ALWAYS = 2'b10
  } poc_oe_e;
endpackage

// File: poc_top.sv
// Array of ten output cells, two term-enabled bidirectional pins and the
// complement NOR term. Assumes synchronous pins and static configuration.
`timescale 1ns/1ps
// Overview of operation
// R1: Unprogrammed clock select uses shared external clock
// R2: Term clock select disconnects external clock
// R3: Ten registers, each independently clocked
// R4: Five cell configurations available per cell
// R5: Bypass keeps buried register and feedback working
// R6: Disabled output lets pin act as input
// R7: Load term high loads register from pin
// R8: Load low and enabled restores configured behaviour
// R9: Registered input needs load high, output off
// R10: Complement term is NOR of connected terms
// R11: Register select chooses D or J-K type
// R12: Shared enable pin low drives output
// R13: Term enable high drives; third setting always on
// R14: Polarity applies only to combinatorial I/O; the code also applies it to dedicated I/O (POC_DED_IO)
// R15: Gate with both input polarities is inactive
// R16: Bidirectional pins enabled only by terms
// R17: Register captures on selected clock rising edge
// R18: Type switch term toggles D/J-K dynamically
// R19: Each cell reset term clears its register
// R20: Configuration inputs are static during operation
module poc_top (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_ext_clk,
  input wire logic i_oe_n,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_clk_sel,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_reg_sel,
  input wire logic [3*poc_pkg::CELL_COUNT-1:0] i_mode,
  input wire logic [2*poc_pkg::CELL_COUNT-1:0] i_oe_sel,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_polarity,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_cell_term_clock,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_load_control_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_type_switch_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_cell_reset_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_d_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_j_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_k_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_comb_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_oe_term,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_pin,
  input wire logic [poc_pkg::TERM_INPUTS-1:0] i_gate_in,
  input wire logic [poc_pkg::TERM_INPUTS-1:0] i_gate_true,
  input wire logic [poc_pkg::TERM_INPUTS-1:0] i_gate_comp,
  input wire logic [poc_pkg::CELL_COUNT-1:0] i_comp_connect,
  input wire logic [1:0] i_bidir_term,
  input wire logic [1:0] i_bidir_oe_term,
  input wire logic [1:0] i_bidir_pin,
  output logic [poc_pkg::CELL_COUNT-1:0] o_pin,
  output logic [poc_pkg::CELL_COUNT-1:0] o_pin_oe,
  output logic [poc_pkg::CELL_COUNT-1:0] o_reg_fb,
  output logic [poc_pkg::CELL_COUNT-1:0] o_pin_fb,
  output logic o_comp_fb,
  output logic o_gate,
  output logic [1:0] o_bidir_pin,
  output logic [1:0] o_bidir_pin_oe,
  output logic [1:0] o_bidir_fb
);
  logic next_gate;
  genvar g;
  // Configuration is sampled as constants: no retiming or change detection [R20]
  generate
    for (g = 0; g < poc_pkg::CELL_COUNT; g++) begin : g_cell // [R3] [R4]
      poc_cell u_cell (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_ext_clk(i_ext_clk),
        .i_clk_sel(i_clk_sel[g]),
        .i_reg_sel(i_reg_sel[g]),
        .i_mode(poc_pkg::poc_mode_e'(i_mode[3*g +: 3])),
        .i_oe_sel(poc_pkg::poc_oe_e'(i_oe_sel[2*g +: 2])),
        .i_polarity(i_polarity[g]),
        .i_cell_term_clock(i_cell_term_clock[g]),
        .i_load_control_term(i_load_control_term[g]),
        .i_type_switch_term(i_type_switch_term[g]),
        .i_cell_reset_term(i_cell_reset_term[g]),
        .i_d_term(i_d_term[g]),
        .i_j_term(i_j_term[g]),
        .i_k_term(i_k_term[g]),
        .i_comb_term(i_comb_term[g]),
        .i_oe_term(i_oe_term[g]),
        .i_oe_n(i_oe_n),
        .i_pin(i_pin[g]),
        .o_pin(o_pin[g]),
        .o_pin_oe(o_pin_oe[g]),
        .o_reg_fb(o_reg_fb[g]),
        .o_pin_fb(o_pin_fb[g])
      );
    end
  endgenerate
  always_comb begin
    next_gate = 1'b1;
    for (int n = 0; n < poc_pkg::TERM_INPUTS; n++) begin
      if (i_gate_true[n] && i_gate_comp[n]) begin
        next_gate = 1'b0; // [R15]
      end else if (i_gate_true[n] && !i_gate_in[n]) begin
        next_gate = 1'b0;
      end else if (i_gate_comp[n] && i_gate_in[n]) begin
        next_gate = 1'b0;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_comp_fb <= 1'b1;
      o_gate <= 1'b0;
    end else if (i_ce) begin
      o_comp_fb <= ~|(i_comp_connect & i_comb_term); // [R10]
      o_gate <= next_gate;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bidir_pin <= 2'b00;
      o_bidir_pin_oe <= 2'b00;
      o_bidir_fb <= 2'b00;
    end else if (i_ce) begin
      o_bidir_pin <= i_bidir_term;
      o_bidir_pin_oe <= i_bidir_oe_term; // [R16]
      o_bidir_fb <= (i_bidir_oe_term & i_bidir_term) | (~i_bidir_oe_term & i_bidir_pin); // [R6]
    end
  end
endmodule // poc_top

// File: poc_top_chk.sv
// Port checker for the cell array.
// Assumes cell 0 reg out, cell 1 inverted comb io, cell 2 reg in.
`timescale 1ns/1ps
module poc_top_chk (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_oe_n,
  input wire logic [9:0] i_comb_term,
  input wire logic [9:0] i_comp_connect,
  input wire logic [9:0] i_oe_term,
  input wire logic [7:0] i_gate_true,
  input wire logic [7:0] i_gate_comp,
  input wire logic [1:0] i_bidir_oe_term,
  input wire logic [9:0] o_pin,
  input wire logic [9:0] o_pin_oe,
  input wire logic [9:0] o_reg_fb,
  input wire logic o_comp_fb,
  input wire logic o_gate,
  input wire logic [1:0] o_bidir_pin_oe
);
  wire logic any_c = |(i_comb_term & i_comp_connect);
  wire logic blk = |(i_gate_true & i_gate_comp);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  property p_comp; $past(i_nrst) |-> o_comp_fb == !$past(any_c); endproperty
  a_comp: assert property (p_comp) else $error("comp fb wrong");
  property p_gate; $past(blk) |-> !o_gate; endproperty
  a_gate: assert property (p_gate) else $error("gate active");
  property p_oep; $past(i_nrst) |-> o_pin_oe[0] == !$past(i_oe_n); endproperty
  a_oep: assert property (p_oep) else $error("pin oe wrong");
  property p_oet; $past(i_nrst) |-> o_pin_oe[1] == $past(i_oe_term[1]); endproperty
  a_oet: assert property (p_oet) else $error("term oe wrong");
  property p_rin; !o_pin_oe[2]; endproperty
  a_rin: assert property (p_rin) else $error("reg in drives");
  property p_bid; $past(i_nrst) |-> o_bidir_pin_oe == $past(i_bidir_oe_term); endproperty
  a_bid: assert property (p_bid) else $error("bidir oe wrong");
  property p_pol; $past(i_nrst) |-> o_pin[1] == !$past(i_comb_term[1]); endproperty
  a_pol: assert property (p_pol) else $error("comb polarity wrong");
  property p_reg; $past(i_nrst) |-> o_pin[0] == !o_reg_fb[0]; endproperty
  a_reg: assert property (p_reg) else $error("reg out not inverted q");
endmodule // poc_top_chk
bind poc_top poc_top_chk u_chk (.*);

// File: test_poc_top.sv
// Testbench for the cell array, one task per scenario.
// Assumes the board model supplies the shared clock and pin levels.
`timescale 1ns/1ps
module test_poc_top;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_oe_n = 1'b1, run = 1'b0, i_ext_clk;
  logic [9:0] i_d_term = 10'h0, i_j_term = 10'h0, i_k_term = 10'h0, i_comb_term = 10'h0;
  logic [9:0] i_oe_term = 10'h0, i_load_control_term = 10'h0, i_cell_reset_term = 10'h0;
  logic [9:0] i_cell_term_clock = 10'h0, i_comp_connect = 10'h006, drv = 10'h0;
  logic [9:0] i_type_switch_term = 10'h0, i_clk_sel = 10'h002, i_reg_sel = 10'h002;
  logic [9:0] i_polarity = 10'h003, i_pin, o_pin, o_pin_oe, o_reg_fb, o_pin_fb;
  logic [29:0] i_mode = 30'h0003850;
  logic [19:0] i_oe_sel = 20'haaaa4;
  logic [7:0] i_gate_in = 8'hff, i_gate_true = 8'hff, i_gate_comp = 8'h0;
  logic [1:0] i_bidir_term = 2'h0, i_bidir_oe_term = 2'h0, i_bidir_pin = 2'h0, o_bidir_pin_oe;
  logic [1:0] o_bidir_pin, o_bidir_fb;
  logic o_comp_fb, o_gate;
  int n_errors = 0, comparisons = 0;
  poc_top u_poc_top (.*);
  poc_board u_poc_board (.i_ref_clk(i_ref_clk), .i_run(run), .i_drive(drv),
    .i_o_pin(o_pin), .i_o_pin_oe(o_pin_oe), .o_ext_clk(i_ext_clk), .o_pin(i_pin));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic frame;
    run = 1'b1;
    cyc(6);
    run = 1'b0;
    cyc(3);
  endtask
  task automatic t_dreg;
    {i_d_term[0], i_j_term[1]} = 2'h3;
    frame;
    chk("fb0", 1'b1, o_reg_fb[0]);
    chk("pin0", 1'b0, o_pin[0]);
    chk("fb1", 1'b0, o_reg_fb[1]);
    $display("t_dreg done");
  endtask
  task automatic t_jk;
    for (int s = 0; s < 3; s++) begin
      {i_j_term[1], i_k_term[1]} = 2'(6'b111110 >> (2 * s));
      i_cell_term_clock[1] = 1'b1;
      cyc(2);
      i_cell_term_clock[1] = 1'b0;
      cyc(3);
      chk("jk fb1", 1'(3'b101 >> s), o_reg_fb[1]);
    end
    $display("t_jk done");
  endtask
  task automatic t_load;
    {i_load_control_term, drv} = {10'h005, 10'h004};
    frame;
    chk("load fb0", 1'b0, o_reg_fb[0]);
    chk("load fb2", 1'b1, o_reg_fb[2]);
    i_load_control_term = 10'h0;
    $display("t_load done");
  endtask
  task automatic t_oe_comp;
    for (int b = 0; b < 2; b++) begin
      {i_oe_n, i_oe_term[1], i_bidir_oe_term[0], i_bidir_term[0]} = {!b[0], {3{b[0]}}};
      {i_comb_term, i_gate_comp} = {b[0] ? 10'h004 : 10'h001, 7'h0, b[0]};
      cyc(2);
      chk("oe0", b[0], o_pin_oe[0]);
      chk("oe1", b[0], o_pin_oe[1]);
      chk("bidir oe", b[0], o_bidir_pin_oe[0]);
      chk("comp", !b[0], o_comp_fb);
      chk("gate", !b[0], o_gate);
    end
    $display("t_oe_comp done");
  endtask
  task automatic t_rst;
    i_cell_reset_term[1] = 1'b1;
    cyc(3);
    chk("rst fb1", 1'b0, o_reg_fb[1]);
    i_cell_reset_term[1] = 1'b0;
    $display("t_rst done");
  endtask
  task automatic t_ded;
    {i_comb_term[3], i_bidir_pin} = 3'b110;
    {i_bidir_oe_term, i_bidir_term} = 4'b0101;
    cyc(2);
    chk("ded io pin3", 1'b1, o_pin[3]);
    chk("ded io oe3", 1'b1, o_pin_oe[3]);
    chk("pin fb3", 1'b1, o_pin_fb[3]);
    chk("ded in oe4", 1'b0, o_pin_oe[4]);
    chk("pin fb4", 1'b0, o_pin_fb[4]);
    chk("pin fb2", 1'b1, o_pin_fb[2]);
    chk("bidir pin0", 1'b1, o_bidir_pin[0]);
    chk("bidir pin1", 1'b0, o_bidir_pin[1]);
    chk("bidir fb0", 1'b1, o_bidir_fb[0]);
    chk("bidir fb1", 1'b1, o_bidir_fb[1]);
    $display("t_ded done");
  endtask
  task automatic t_type;
    {i_type_switch_term[0], i_d_term[0], i_j_term[0], i_k_term[0]} = 4'b1100;
    frame;
    chk("type jk hold fb0", 1'b0, o_reg_fb[0]);
    i_type_switch_term[0] = 1'b0;
    frame;
    chk("type d fb0", 1'b1, o_reg_fb[0]);
    $display("t_type done");
  endtask
  task automatic t_freeze;
    {i_j_term[1], i_k_term[1], i_ce} = 3'b110;
    i_cell_term_clock[1] = 1'b1;
    cyc(2);
    i_cell_term_clock[1] = 1'b0;
    cyc(2);
    i_ce = 1'b1;
    cyc(2);
    chk("freeze fb1", 1'b0, o_reg_fb[1]);
    i_cell_term_clock[1] = 1'b1;
    cyc(2);
    i_cell_term_clock[1] = 1'b0;
    cyc(2);
    chk("thaw fb1", 1'b1, o_reg_fb[1]);
    $display("t_freeze done");
  endtask
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    i_nrst = 1'b1;
    cyc(2);
    t_dreg;
    t_jk;
    t_load;
    t_oe_comp;
    t_rst;
    t_ded;
    t_type;
    t_freeze;
    final_report;
  end
  initial begin
    #3000;
    n_errors++;
    final_report;
  end
endmodule // test_poc_top
